// ---- rtl/mem_map_consts.vh ----
/*
  Constants for the memory map block: direct-address layout, special
  register offsets, program-store vectors and sizes, sample-store sizes.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef MEM_MAP_CONSTS_VH
`define MEM_MAP_CONSTS_VH

`define ADDR_ROM_ADDR_NIBBLE0   6'h18
`define ADDR_ROM_ADDR_NIBBLE1   6'h19
`define ADDR_ROM_ADDR_NIBBLE2   6'h1a
`define ADDR_ROM_ADDR_NIBBLE3   6'h1b
`define ADDR_ROM_DATA_LOW       6'h1c
`define ADDR_ROM_DATA_HIGH      6'h1d
`define ADDR_GENERAL_NIBBLE_A   6'h07
`define ADDR_GENERAL_NIBBLE_B   6'h0f
`define SFR_LAST                6'h1f
`define SRAM_WINDOW_FIRST       6'h20
`define SRAM_PAGE_COUNT         2'h3
`define SRAM_PAGE_NIBBLES       32
`define SRAM_NIBBLES            96

`define PROG_WORD_WIDTH         12
`define PROG_LAST_SMALL         13'h0fff
`define PROG_LAST_LARGE         13'h1fff
`define PROG_RESERVED_SMALL     13'h0f00
`define PROG_RESERVED_LARGE     13'h1f00
`define PROG_RESERVED_WORDS     256
`define FILL_RESERVED           12'hfff
`define FILL_PLAIN              12'h000
`define VEC_RESET               13'h0000
`define VEC_WAKEUP              13'h0004
`define VEC_INTERRUPT           13'h0008
`define VEC_USER                13'h000a

`define SAMPLE_LAST_SMALL       16'hdfff
`define SAMPLE_LAST_LARGE       16'hbfff
`define SAMPLE_SYSTEM_SMALL     16'hdfc0
`define SAMPLE_SYSTEM_LARGE     16'hbfc0
`define SAMPLE_SYSTEM_BYTES     64

`define FSYS_PERIODS_READY      2
`define CLK_PERIOD_NS           5

`endif

// ---- rtl/sample_store_reader.v ----
/*
  Sample store read pipeline: a byte array addressed by the 16-bit address
  from the nibble registers, with a registered output.
  Assumes the contents are loaded by the image builder through the init
  port; unused bytes are given by the fill option.
*/
`timescale 1ns/1ps
`include "mem_map_consts.vh"

module sample_store_reader #(
  parameter DEPTH = 57344
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire [15:0] i_addr,
  input  wire        i_init_we,
  input  wire [15:0] i_init_addr,
  input  wire [7:0]  i_init_data,
  output reg  [7:0]  o_data
);

  reg [7:0] store [0:DEPTH-1];

  // The load port writes the store on any cycle with i_init_we high and an address below DEPTH, even while the core runs.
  always @(posedge i_clk_sys)
  begin
    if (i_init_we && ({16'h0000, i_init_addr} < DEPTH))
    begin
      store[i_init_addr] <= i_init_data;
    end
  end

  // Single registered read; the caller adds one more stage.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_data <= 8'h00;
    end
    else if ({16'h0000, i_addr} < DEPTH)
    begin
      o_data <= store[i_addr]; // see RULE5 see RULE6
    end
    else
    begin
      o_data <= 8'h00;
    end
  end

endmodule

// ---- rtl/mem_map.v ----
/*
  Memory map of the 4-bit core: program store with vectors, sample store
  reached through four address nibbles and two data nibbles, paged nibble
  SRAM behind a common special register block.
  Assumes the core issues one direct access per cycle on the nibble bus and
  keeps its own register timing; other special registers live elsewhere.
*/
`timescale 1ns/1ps
`include "mem_map_consts.vh"

// Contract
// RULE1 - 12-bit program words, 4K or 8K
// RULE2 - last 256 program words reserved, unchecked
// RULE3 - image builder fills unused words per option
// RULE4 - vectors 0x000 reset, 0x004 wakeup, 0x008 irq
// RULE5 - sample store bytes, 56K or 48K
// RULE6 - last 64 sample bytes system area, unchecked
// RULE7 - 16-bit address from four nibbles, low first
// RULE8 - software waits ready delay before data read
// RULE9 - byte ready within two clocks of address
// RULE10 - low register bits 3:0, high bits 7:4
// RULE11 - high register write clears watchdog
// RULE12 - 2-bit page register selects SRAM page
// RULE13 - page register unset by reset, software loads
// RULE14 - 00H-1FH always special registers
// RULE15 - 20H-3FH paged SRAM, 96 nibbles total
// RULE16 - SRAM contents undefined after reset
// RULE17 - two extra nibbles are general registers
// RULE18 - access registers at 18H through 1DH
// RULE19 - read uses current address nibbles, any order
module mem_map #(
  parameter LARGE_PROG = 0,
  parameter WDT_ENABLE = 1
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire [5:0]  i_addr,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [3:0]  i_wdata,
  input  wire        i_page_load,
  input  wire [1:0]  i_page_value,
  input  wire [12:0] i_prog_addr,
  input  wire        i_prog_init_we,
  input  wire [12:0] i_prog_init_addr,
  input  wire [11:0] i_prog_init_data,
  input  wire        i_sample_init_we,
  input  wire [15:0] i_sample_init_addr,
  input  wire [7:0]  i_sample_init_data,
  input  wire        i_vec_reset,
  input  wire        i_vec_wakeup,
  input  wire        i_vec_interrupt,
  output reg  [3:0]  o_rdata,
  output reg         o_sfr_sel,
  output reg  [11:0] o_prog_word,
  output reg  [12:0] o_vector,
  output reg         o_vector_valid,
  output reg         o_wdt_clear,
  output reg         o_sample_ready
);

  localparam PROG_DEPTH   = LARGE_PROG ? 8192 : 4096;
  localparam SAMPLE_DEPTH = LARGE_PROG ? 49152 : 57344;
  localparam [12:0] PROG_MASK = LARGE_PROG ? `PROG_LAST_LARGE : `PROG_LAST_SMALL;
  localparam [1:0]  READY_CYCLES = `FSYS_PERIODS_READY;

  reg [3:0]  rom_addr_nibble0;
  reg [3:0]  rom_addr_nibble1;
  reg [3:0]  rom_addr_nibble2;
  reg [3:0]  rom_addr_nibble3;
  reg [3:0]  general_nibble_a;
  reg [3:0]  general_nibble_b;
  reg [1:0]  ram_page_select;
  reg [3:0]  sram [0:`SRAM_NIBBLES-1];
  reg [11:0] program_store [0:8191];
  reg [7:0]  sample_byte;
  reg [1:0]  ready_count;
  wire [7:0] sample_raw;
  wire [15:0] sample_addr;
  wire       in_sfr;
  wire       in_sram;
  wire       page_ok;
  wire [6:0] sram_index;
  wire       addr_write;
  wire [3:0] nibble_we;
  reg [1:0]  next_ready_count;
  reg        next_sample_ready;
  reg [12:0] next_vector;
  genvar     nib;

  // Address is always the live concatenation, so write order does not matter.
  assign sample_addr = {rom_addr_nibble3, rom_addr_nibble2,
                        rom_addr_nibble1, rom_addr_nibble0}; // see RULE7 see RULE19

  assign in_sfr  = (i_addr <= `SFR_LAST); // see RULE14
  assign in_sram = (i_addr >= `SRAM_WINDOW_FIRST);
  assign page_ok = (ram_page_select < `SRAM_PAGE_COUNT); // see RULE12
  assign sram_index = {ram_page_select, i_addr[4:0]}; // see RULE15

  // One strobe per address nibble; any of them restarts the ready delay.
  generate
    for (nib = 0; nib < 4; nib = nib + 1)
    begin : g_nibble_we
      localparam [5:0] NIB_ADDR = `ADDR_ROM_ADDR_NIBBLE0 + nib;
      assign nibble_we[nib] = i_wr && (i_addr == NIB_ADDR); // see RULE18
    end
  endgenerate

  assign addr_write = |nibble_we;

  sample_store_reader #(
    .DEPTH (SAMPLE_DEPTH)
  ) u_reader (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_addr      (sample_addr),
    .i_init_we   (i_sample_init_we),
    .i_init_addr (i_sample_init_addr),
    .i_init_data (i_sample_init_data),
    .o_data      (sample_raw)
  );

  // Access registers and general nibbles; reset leaves them at zero for determinism.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rom_addr_nibble0 <= 4'h0;
      rom_addr_nibble1 <= 4'h0;
      rom_addr_nibble2 <= 4'h0;
      rom_addr_nibble3 <= 4'h0;
      general_nibble_a <= 4'h0;
      general_nibble_b <= 4'h0;
    end
    else if (i_wr)
    begin
      case (i_addr) // see RULE18
        `ADDR_ROM_ADDR_NIBBLE0: rom_addr_nibble0 <= i_wdata;
        `ADDR_ROM_ADDR_NIBBLE1: rom_addr_nibble1 <= i_wdata;
        `ADDR_ROM_ADDR_NIBBLE2: rom_addr_nibble2 <= i_wdata;
        `ADDR_ROM_ADDR_NIBBLE3: rom_addr_nibble3 <= i_wdata;
        `ADDR_GENERAL_NIBBLE_A: general_nibble_a <= i_wdata; // see RULE17
        `ADDR_GENERAL_NIBBLE_B: general_nibble_b <= i_wdata; // see RULE17
        default: general_nibble_a <= general_nibble_a;
      endcase
    end
  end

  // The page register has no reset; software must load it first.
  always @(posedge i_clk_sys)
  begin
    if (i_page_load)
    begin
      ram_page_select <= i_page_value; // see RULE13
    end
  end

  // SRAM has no reset path, so its contents start undefined.
  always @(posedge i_clk_sys)
  begin
    if (i_wr && in_sram && page_ok)
    begin
      sram[sram_index] <= i_wdata; // see RULE16
    end
  end

  // Program store loaded by the builder; reserved words are not guarded.
  always @(posedge i_clk_sys)
  begin
    if (i_prog_init_we && ({3'b000, i_prog_init_addr} < PROG_DEPTH))
    begin
      program_store[i_prog_init_addr] <= i_prog_init_data; // see RULE3
    end
  end

  // Ready is a level, so software may poll it instead of counting cycles;
  // a new address write restarts the count.
  always @*
  begin
    next_ready_count  = ready_count;
    next_sample_ready = o_sample_ready;
    if (addr_write)
    begin
      next_ready_count  = READY_CYCLES;
      next_sample_ready = 1'b0;
    end
    else if (ready_count != 2'h0)
    begin
      next_ready_count  = ready_count - 2'h1;
      next_sample_ready = (ready_count == 2'h1);
    end
    else
    begin
      next_sample_ready = 1'b1;
    end
  end

  // The reader is registered once; this stage lands the byte on cycle two.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sample_byte    <= 8'h00;
      ready_count    <= 2'h0;
      o_sample_ready <= 1'b0;
    end
    else
    begin
      sample_byte    <= sample_raw; // see RULE9
      ready_count    <= next_ready_count;
      o_sample_ready <= next_sample_ready; // see RULE9
    end
  end

  // Read mux; bytes in the system area are served like any other.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata   <= 4'h0;
      o_sfr_sel <= 1'b0;
    end
    else
    begin
      o_sfr_sel <= (i_rd || i_wr) && in_sfr; // see RULE14
      if (!i_rd)
      begin
        o_rdata <= 4'h0;
      end
      else if (in_sram)
      begin
        o_rdata <= page_ok ? sram[sram_index] : 4'h0;
      end
      else
      begin
        case (i_addr)
          `ADDR_ROM_ADDR_NIBBLE0: o_rdata <= rom_addr_nibble0;
          `ADDR_ROM_ADDR_NIBBLE1: o_rdata <= rom_addr_nibble1;
          `ADDR_ROM_ADDR_NIBBLE2: o_rdata <= rom_addr_nibble2;
          `ADDR_ROM_ADDR_NIBBLE3: o_rdata <= rom_addr_nibble3;
          `ADDR_ROM_DATA_LOW:     o_rdata <= sample_byte[3:0]; // see RULE10
          `ADDR_ROM_DATA_HIGH:    o_rdata <= sample_byte[7:4]; // see RULE10
          `ADDR_GENERAL_NIBBLE_A: o_rdata <= general_nibble_a;
          `ADDR_GENERAL_NIBBLE_B: o_rdata <= general_nibble_b;
          default:                o_rdata <= 4'h0;
        endcase
      end
    end
  end

  // Writing the high data nibble only feeds the watchdog; the value is dropped.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_wdt_clear <= 1'b0;
    end
    else
    begin
      o_wdt_clear <= (WDT_ENABLE != 0) && i_wr &&
                     (i_addr == `ADDR_ROM_DATA_HIGH); // see RULE11
    end
  end

  // Program fetch wraps at the selected size; the reserved tail is readable.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prog_word <= `FILL_PLAIN;
    end
    else
    begin
      o_prog_word <= program_store[i_prog_addr & PROG_MASK]; // see RULE1 see RULE2
    end
  end

  // Reset outranks interrupt, which outranks wakeup.
  always @*
  begin
    next_vector = o_vector;
    if (i_vec_reset)
    begin
      next_vector = `VEC_RESET; // see RULE4
    end
    else if (i_vec_interrupt)
    begin
      next_vector = `VEC_INTERRUPT; // see RULE4
    end
    else if (i_vec_wakeup)
    begin
      next_vector = `VEC_WAKEUP; // see RULE4
    end
  end

  // The last vector is held between requests so a late core still sees it.
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_vector       <= `VEC_RESET;
      o_vector_valid <= 1'b1;
    end
    else
    begin
      o_vector       <= next_vector;
      o_vector_valid <= i_vec_reset || i_vec_interrupt || i_vec_wakeup;
    end
  end

endmodule

// ---- verification/mem_map_asserts.sv ----
/*
  Port-timing checker for mem_map: watchdog pulse, special block select,
  sample-store ready, idle read data and vector choice.
  Assumes it is bound to every mem_map instance and shares its parameters.
*/
`timescale 1ns/1ps
module mem_map_asserts #(
  parameter LARGE_PROG = 0,
  parameter WDT_ENABLE = 1
) (
  input wire        i_clk_sys,
  input wire        i_rst_n,
  input wire [5:0]  i_addr,
  input wire        i_wr,
  input wire        i_rd,
  input wire        i_vec_reset,
  input wire        i_vec_wakeup,
  input wire        i_vec_interrupt,
  input wire [3:0]  o_rdata,
  input wire        o_sfr_sel,
  input wire [12:0] o_vector,
  input wire        o_vector_valid,
  input wire        o_wdt_clear,
  input wire        o_sample_ready
);
  wire nib_wr;
  assign nib_wr = i_wr && (i_addr >= 6'h18) && (i_addr <= 6'h1b);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wdt_pulse_a : assert property (
    i_wr && i_addr == 6'h1d |=> o_wdt_clear == (WDT_ENABLE != 0)) else $error("no wdt clear");
  wdt_quiet_a : assert property (
    !(i_wr && i_addr == 6'h1d) |=> !o_wdt_clear) else $error("stray wdt clear");
  sfr_sel_a : assert property (
    i_wr || i_rd |=> o_sfr_sel == ($past(i_addr) <= 6'h1f)) else $error("bad sfr select");
  ready_low_a : assert property (
    nib_wr |=> !o_sample_ready) else $error("ready stayed high");
  ready_due_a : assert property (
    nib_wr ##1 !nib_wr ##1 !nib_wr |=> o_sample_ready) else $error("ready late");
  rdata_idle_a : assert property (
    !i_rd |=> o_rdata == 4'h0) else $error("read data without read");
  vec_reset_a : assert property (
    i_vec_reset |=> o_vector_valid && o_vector == 13'h0000) else $error("bad reset vector");
  vec_irq_a : assert property (
    i_vec_interrupt && !i_vec_reset |=> o_vector == 13'h0008) else $error("bad irq vector");
  vec_wake_a : assert property (
    i_vec_wakeup && !i_vec_reset && !i_vec_interrupt |=> o_vector == 13'h0004)
    else $error("bad wakeup vector");
  cover property (i_wr && i_addr == 6'h1d);
  cover property (nib_wr ##4 (i_rd && i_addr == 6'h1c));
  cover property (i_vec_interrupt && i_vec_reset);
endmodule

bind mem_map mem_map_asserts #(.LARGE_PROG(LARGE_PROG), .WDT_ENABLE(WDT_ENABLE)) u_chk (
  .i_clk_sys, .i_rst_n, .i_addr, .i_wr, .i_rd, .i_vec_reset, .i_vec_wakeup,
  .i_vec_interrupt, .o_rdata, .o_sfr_sel, .o_vector, .o_vector_valid, .o_wdt_clear,
  .o_sample_ready);

// ---- verification/core_model.sv ----
/*
  Model of the 4-bit core on the nibble bus: direct writes, reads and page loads.
  Assumes the bench calls its tasks only after reset is released.
*/
`timescale 1ns/1ps
module core_model (
  input  wire       i_clk_sys,
  input  wire [3:0] i_rdata,
  output reg  [5:0] o_addr = 6'h00,
  output reg        o_wr = 1'b0,
  output reg        o_rd = 1'b0,
  output reg  [3:0] o_wdata = 4'h0,
  output reg        o_page_load = 1'b0,
  output reg  [1:0] o_page_value = 2'h0
);
  // Released lines show the inverse so a design that samples late sees junk.
  task wr(input [5:0] a, input [3:0] d);
  begin
    @(posedge i_clk_sys);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  end
  endtask
  // A read is taken at the second edge of the call; callers wait out the data delay first.
  task rd(input [5:0] a, output [3:0] d);
  begin
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  end
  endtask
  task page(input [1:0] p);
  begin
    @(posedge i_clk_sys);
    o_page_load  <= 1'b1;
    o_page_value <= p;
    @(posedge i_clk_sys);
    o_page_load  <= 1'b0;
    o_page_value <= ~p;
  end
  endtask
endmodule

// ---- verification/mem_map_tb.sv ----
/*
  Self-checking bench for mem_map through the core model.
  Assumes the 4K program / 56K sample build with the watchdog option on.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done = checks_done + 1; if ((a) !== (e)) begin \
  failures = failures + 1; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mem_map_tb;
  reg         i_clk_sys = 1'b0;
  reg         i_rst_n = 1'b0;
  reg  [12:0] prog_addr = 13'h0, pi_addr = 13'h0;
  reg         pi_we = 1'b0, si_we = 1'b0, v_rst = 1'b0, v_wake = 1'b0, v_irq = 1'b0;
  reg  [11:0] pi_data = 12'h0;
  reg  [15:0] si_addr = 16'h0;
  reg  [7:0]  si_data = 8'h0;
  reg  [3:0]  d;
  wire [5:0]  addr;
  wire [3:0]  wdata, o_rdata;
  wire [1:0]  pval;
  wire        wr, rd, pload, o_sfr_sel, o_vector_valid, o_wdt_clear, o_sample_ready;
  wire [11:0] o_prog_word;
  wire [12:0] o_vector;
  integer     failures = 0, checks_done = 0, k;
  always #2.5 i_clk_sys = ~i_clk_sys;
  core_model u_core (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdata), .o_page_load(pload), .o_page_value(pval));
  mem_map #(.LARGE_PROG(0), .WDT_ENABLE(1)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .i_page_load(pload),
    .i_page_value(pval), .i_prog_addr(prog_addr), .i_prog_init_we(pi_we),
    .i_prog_init_addr(pi_addr), .i_prog_init_data(pi_data), .i_sample_init_we(si_we),
    .i_sample_init_addr(si_addr), .i_sample_init_data(si_data), .i_vec_reset(v_rst),
    .i_vec_wakeup(v_wake), .i_vec_interrupt(v_irq), .o_rdata(o_rdata),
    .o_sfr_sel(o_sfr_sel), .o_prog_word(o_prog_word), .o_vector(o_vector),
    .o_vector_valid(o_vector_valid), .o_wdt_clear(o_wdt_clear),
    .o_sample_ready(o_sample_ready));
  task give_verdict;
  begin
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  // Address nibbles go in top-first to show the order does not matter.
  task rom_chk(input [15:0] a, input [7:0] v);
  begin
    @(posedge i_clk_sys);
    si_we <= 1'b1; si_addr <= a; si_data <= v;
    @(posedge i_clk_sys);
    si_we <= 1'b0;
    for (k = 3; k >= 0; k = k - 1)
      u_core.wr(6'h18 + k[5:0], a[4*k +: 4]);
    #1 `CHK(o_sample_ready, 1'b0)
    repeat (2) @(posedge i_clk_sys);
    #1 `CHK(o_sample_ready, 1'b1)
    u_core.rd(6'h1c, d); `CHK(d, v[3:0])
    u_core.rd(6'h1d, d); `CHK(d, v[7:4])
    u_core.rd(6'h18, d); `CHK(d, a[3:0])
    `CHK(o_sfr_sel, 1'b1)
  end
  endtask
  task fetch(input [12:0] a, input [11:0] w);
  begin
    @(posedge i_clk_sys);
    pi_we <= 1'b1; pi_addr <= a; pi_data <= w;
    @(posedge i_clk_sys);
    pi_we <= 1'b0; prog_addr <= a | 13'h1000;
    @(posedge i_clk_sys);
    #1 `CHK(o_prog_word, w)
  end
  endtask
  task vec(input [2:0] r, input [12:0] v);
  begin
    @(posedge i_clk_sys);
    {v_rst, v_irq, v_wake} <= r;
    @(posedge i_clk_sys);
    {v_rst, v_irq, v_wake} <= 3'b000;
    #1 `CHK(o_vector, v)
    `CHK(o_vector_valid, 1'b1)
  end
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge i_clk_sys);
    `CHK(o_vector_valid, 1'b1)
    i_rst_n <= 1'b1;
    k = 0;
    while (o_sample_ready !== 1'b1 && k < 4) begin
      @(posedge i_clk_sys);
      #1 k = k + 1;
    end
    if (k == 4) begin
      failures = failures + 1;
      give_verdict;
    end
    rom_chk(16'h1234, 8'ha5);
    rom_chk(16'h0000, 8'h96);
    rom_chk(16'hdfc0, 8'h3c);
    rom_chk(16'hdfff, 8'hc3);
    u_core.wr(6'h1c, 4'h0);
    u_core.rd(6'h1c, d); `CHK(d, 4'h3)
    u_core.wr(6'h1d, 4'h0);
    #1 `CHK(o_wdt_clear, 1'b1)
    for (k = 0; k < 3; k = k + 1) begin
      u_core.page(k[1:0]);
      u_core.wr(6'h20, k[3:0] + 4'h1);
      u_core.wr(6'h3f, k[3:0] + 4'h8);
    end
    for (k = 0; k < 3; k = k + 1) begin
      u_core.page(k[1:0]);
      u_core.rd(6'h20, d); `CHK(d, k[3:0] + 4'h1)
      u_core.rd(6'h3f, d); `CHK(d, k[3:0] + 4'h8)
      `CHK(o_sfr_sel, 1'b0)
    end
    u_core.wr(6'h07, 4'h9);
    u_core.wr(6'h0f, 4'h6);
    u_core.page(2'h1);
    u_core.rd(6'h07, d); `CHK(d, 4'h9)
    u_core.rd(6'h0f, d); `CHK(d, 4'h6)
    fetch(13'h0000, 12'h123);
    fetch(13'h0f00, 12'h456);
    fetch(13'h0fff, 12'h789);
    fetch(13'h0200, 12'hfff);
    vec(3'b100, 13'h0000);
    vec(3'b010, 13'h0008);
    vec(3'b001, 13'h0004);
    vec(3'b110, 13'h0000);
    give_verdict;
  end
endmodule
